//--- shared/rcm_defines.svh
// register map, field positions, reset values and timing figures of the measurement unit
`ifndef RCM_DEFINES_SVH
`define RCM_DEFINES_SVH

`define RCM_ADDR_W 4
`define RCM_OFF_MEASURE_CONTROL 4'h0
`define RCM_OFF_CLOCK_RUN_CONTROL 4'h1
`define RCM_OFF_REF_COUNT_LOW 4'h2
`define RCM_OFF_REF_COUNT_HIGH 4'h3
`define RCM_OFF_OSC_COUNT_LOW 4'h4
`define RCM_OFF_OSC_COUNT_HIGH 4'h5
`define RCM_OFF_IRQ_STATUS 4'h6
`define RCM_OFF_IRQ_MASK 4'h7
`define RCM_OFF_ANALOG_SWITCH_CONTROL 4'h8

`define RCM_BIT_OVERFLOW_SOURCE_SELECT 0
`define RCM_BIT_UNIT_ENABLE 1
`define RCM_BIT_RUN 4
`define RCM_SEL_LSB 5
`define RCM_SEL_MSB 7
`define RCM_BIT_UNIT_IRQ_FLAG 4

`define RCM_SEL_SYSCLK 3'h0
`define RCM_SEL_SYSCLK_DIV4 3'h1
`define RCM_REF_DIVIDE 2'h3
`define RCM_RESET_BYTE 8'h00
`define RCM_RESET_COUNT 16'h0000

`endif

//--- shared/rcm_pkg.sv
// types shared by the measurement unit and its bench
package rcm_pkg;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wrData;
    logic wr;
    logic rd;
  } rcm_bus_req_t;

  typedef enum logic [0:0] {
    RCM_CNT_REF,
    RCM_CNT_OSC
  } rcm_counter_id_t;

endpackage

//--- core/rcm_measure_unit.sv
// resistor-capacitor oscillation measurement unit with register port
//
// Behaviour
// R1 - two 16-bit up-counters: reference and oscillation
// R2 - unit active only while enable bit set
// R3 - reference clock is sysclk or sysclk/4
// R4 - oscillation counter counts external oscillator cycles
// R5 - source select picks which overflow interrupts
// R6 - enable with source clear selects reference overflow
// R7 - run bit starts both counters together
// R8 - selected overflow sets unit interrupt flag
// R9 - any overflow halts both and clears run
// R10 - counter bytes inaccessible while run high
// R11 - low-byte write goes to holding buffer
// R12 - high-byte write also commits held low byte
// R13 - high-byte read latches low byte for reading
// R14 - software writes low byte before high
// R15 - eight analog switch lines for keys
// R16 - fixed choice: port-D pins or oscillator input
// R17 - fixed choice: port-B pins or switch lines
// R18 - interrupt flag stays until software clears it
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rcm_defines.svh"

module rcm_measure_unit
(
  input wire logic clock,
  input wire logic rstn,
  input wire rcm_pkg::rcm_bus_req_t busReq,
  output logic [7:0] regRdData,
  input wire logic [3:0] pdPinIn,
  input wire logic pdShareOscStrap,
  input wire logic pbShareSwitchStrap,
  input wire logic [7:0] pbGpioOut,
  input wire logic [7:0] pbGpioOe,
  output logic [3:0] pdGpioIn,
  output logic [7:0] pbPinOut,
  output logic [7:0] pbPinOe,
  output logic irq
);

  // ****************************************
  // fixed configuration
  // ****************************************
  logic pdOscSel_q;
  logic pbSwSel_q;

  // straps sampled while reset is held and kept after release
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      pdOscSel_q <= pdShareOscStrap;
      pbSwSel_q <= pbShareSwitchStrap;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  logic [7:0] measCtrl_q;
  logic [7:0] clkRun_q;
  logic [7:0] irqStat_q;
  logic [7:0] irqMask_q;
  logic [7:0] switchCtrl_q;
  logic runClear;
  logic flagSet;
  logic wrHit;
  logic [2:0] refSel;
  logic unitOn;
  logic running;

  assign refSel = clkRun_q[`RCM_SEL_MSB:`RCM_SEL_LSB];
  assign unitOn = measCtrl_q[`RCM_BIT_UNIT_ENABLE]; // [R2]
  assign running = clkRun_q[`RCM_BIT_RUN];
  assign wrHit = busReq.wr;

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      measCtrl_q <= `RCM_RESET_BYTE;
      irqMask_q <= `RCM_RESET_BYTE;
      switchCtrl_q <= `RCM_RESET_BYTE;
    end
    else if (wrHit)
    begin
      case (busReq.addr)
        `RCM_OFF_MEASURE_CONTROL:
        begin
          measCtrl_q <= busReq.wrData; // [R6]
        end
        `RCM_OFF_IRQ_MASK:
        begin
          irqMask_q <= busReq.wrData;
        end
        `RCM_OFF_ANALOG_SWITCH_CONTROL:
        begin
          switchCtrl_q <= busReq.wrData;
        end
        default:
        begin
        end
      endcase
    end
  end

  // overflow clears the run bit even against a write in the same cycle
  // the run bit only takes while the unit is enabled, so a disabled unit never counts
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      clkRun_q <= `RCM_RESET_BYTE;
    end
    else if (runClear)
    begin
      clkRun_q[`RCM_BIT_RUN] <= 1'b0; // [R9]
    end
    else if (wrHit && busReq.addr == `RCM_OFF_CLOCK_RUN_CONTROL)
    begin
      clkRun_q <= busReq.wrData;
      clkRun_q[`RCM_BIT_RUN] <= busReq.wrData[`RCM_BIT_RUN] & unitOn; // [R2] [R7]
    end
  end

  // sticky flag: write one to clear, a new overflow wins over the clear
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      irqStat_q <= `RCM_RESET_BYTE;
    end
    else
    begin
      if (wrHit && busReq.addr == `RCM_OFF_IRQ_STATUS)
      begin
        irqStat_q <= irqStat_q & ~busReq.wrData; // [R18]
      end
      if (flagSet)
      begin
        irqStat_q[`RCM_BIT_UNIT_IRQ_FLAG] <= 1'b1; // [R8]
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(irqStat_q & irqMask_q);
    end
  end

  // ****************************************
  // counting ticks
  // ****************************************
  logic [1:0] div_q;
  logic oscPrev_q;
  logic oscLevel;
  logic [1:0] tick;
  logic [1:0] carry;
  logic [15:0] count_q [2];

  assign oscLevel = pdOscSel_q & pdPinIn[0]; // [R16]

  // divide-by-four phase, held at zero while the counters stand
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      div_q <= 2'h0;
    end
    else
    begin
      div_q <= (running && unitOn) ? div_q + 2'h1 : 2'h0;
    end
  end

  // previous oscillator level for rising-edge detection
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      oscPrev_q <= 1'b0;
    end
    else
    begin
      oscPrev_q <= oscLevel;
    end
  end

  always_comb
  begin
    tick[rcm_pkg::RCM_CNT_REF] = running && unitOn &&
      (refSel != `RCM_SEL_SYSCLK_DIV4 || div_q == `RCM_REF_DIVIDE); // [R3] [R7]
    tick[rcm_pkg::RCM_CNT_OSC] = running && unitOn && oscLevel && !oscPrev_q; // [R4]
  end

  assign runClear = |carry; // [R9]
  assign flagSet = measCtrl_q[`RCM_BIT_OVERFLOW_SOURCE_SELECT] ? carry[1] : carry[0]; // [R5]

  // ****************************************
  // counters and byte access
  // ****************************************
  logic [7:0] lowBuf_q [2];
  logic [7:0] lowLatch_q [2];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_cnt
      localparam logic [3:0] OffLow = (gi == 0) ? `RCM_OFF_REF_COUNT_LOW : `RCM_OFF_OSC_COUNT_LOW;
      localparam logic [3:0] OffHigh = (gi == 0) ? `RCM_OFF_REF_COUNT_HIGH : `RCM_OFF_OSC_COUNT_HIGH;
      logic open;
      logic lowWr;
      logic highWr;
      logic highRd;

      // counter bytes are shut off from the bus while the run bit stands
      assign open = !running; // [R10]
      assign lowWr = wrHit && open && busReq.addr == OffLow;
      assign highWr = wrHit && open && busReq.addr == OffHigh;
      assign highRd = busReq.rd && open && busReq.addr == OffHigh;

      // the counter wraps past all ones on its next tick
      assign carry[gi] = tick[gi] && (&count_q[gi]);

      // low-byte holding buffer
      always_ff @(posedge clock)
      begin
        if (!rstn)
        begin
          lowBuf_q[gi] <= `RCM_RESET_BYTE;
        end
        else if (lowWr)
        begin
          lowBuf_q[gi] <= busReq.wrData; // [R11]
        end
      end

      // both counters freeze together on any overflow
      always_ff @(posedge clock)
      begin
        if (!rstn)
        begin
          count_q[gi] <= `RCM_RESET_COUNT;
        end
        else if (highWr)
        begin
          count_q[gi] <= {busReq.wrData, lowBuf_q[gi]}; // [R12]
        end
        else if (tick[gi] && !runClear)
        begin
          count_q[gi] <= count_q[gi] + 16'h0001; // [R1]
        end
        else if (carry[gi])
        begin
          count_q[gi] <= `RCM_RESET_COUNT;
        end
      end

      // a high-byte read freezes the low byte for the following low read
      always_ff @(posedge clock)
      begin
        if (!rstn)
        begin
          lowLatch_q[gi] <= `RCM_RESET_BYTE;
        end
        else if (highRd)
        begin
          lowLatch_q[gi] <= count_q[gi][7:0]; // [R13]
        end
      end
    end
  endgenerate

  // ****************************************
  // read port and pins
  // ****************************************
  logic [7:0] rdMux;

  always_comb
  begin
    rdMux = 8'h00;
    case (busReq.addr)
      `RCM_OFF_MEASURE_CONTROL:
      begin
        rdMux = {6'h00, measCtrl_q[1:0]};
      end
      `RCM_OFF_CLOCK_RUN_CONTROL:
      begin
        rdMux = clkRun_q;
      end
      `RCM_OFF_REF_COUNT_LOW:
      begin
        rdMux = running ? 8'h00 : lowLatch_q[0]; // [R10]
      end
      `RCM_OFF_REF_COUNT_HIGH:
      begin
        rdMux = running ? 8'h00 : count_q[0][15:8];
      end
      `RCM_OFF_OSC_COUNT_LOW:
      begin
        rdMux = running ? 8'h00 : lowLatch_q[1];
      end
      `RCM_OFF_OSC_COUNT_HIGH:
      begin
        rdMux = running ? 8'h00 : count_q[1][15:8];
      end
      `RCM_OFF_IRQ_STATUS:
      begin
        rdMux = irqStat_q;
      end
      `RCM_OFF_IRQ_MASK:
      begin
        rdMux = irqMask_q;
      end
      `RCM_OFF_ANALOG_SWITCH_CONTROL:
      begin
        rdMux = switchCtrl_q;
      end
      default:
      begin
        rdMux = 8'h00;
      end
    endcase
  end

  // read data stand for one cycle only, zero otherwise
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      regRdData <= 8'h00;
    end
    else
    begin
      regRdData <= busReq.rd ? rdMux : 8'h00;
    end
  end

  // switch lines drive port B only when the strap selects them
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      pbPinOut <= 8'h00;
    end
    else
    begin
      pbPinOut <= pbSwSel_q ? switchCtrl_q : pbGpioOut; // [R15] [R17]
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      pbPinOe <= 8'h00;
    end
    else
    begin
      pbPinOe <= pbSwSel_q ? 8'hFF : pbGpioOe; // [R17]
    end
  end

  // port-D pins read as zero while they carry the oscillator
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      pdGpioIn <= 4'h0;
    end
    else
    begin
      pdGpioIn <= pdOscSel_q ? 4'h0 : pdPinIn; // [R16]
    end
  end

endmodule

`default_nettype wire

//--- verification/rcm_monitor.sv
// port checks of the measurement unit
`timescale 1ns/1ps
`default_nettype none
module rcm_monitor
(
  input wire logic clock,
  input wire logic rstn,
  input wire rcm_pkg::rcm_bus_req_t busReq,
  input wire logic [7:0] regRdData,
  input wire logic pbShareSwitchStrap,
  input wire logic [7:0] pbPinOut,
  input wire logic [7:0] pbPinOe,
  input wire logic irq
);
  // ****
  // checks
  // ****
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  wire logic irqWr = busReq.wr && (busReq.addr inside {4'h6, 4'h7});
  sequence mcWrRd;
    busReq.wr && busReq.addr == 4'h0 ##1 busReq.rd && busReq.addr == 4'h0;
  endsequence
  AST_RD_IDLE: assert property (!busReq.rd |=> regRdData == 8'h00)
    else $error("read data outside read slot");
  AST_UNMAPPED: assert property (busReq.rd && busReq.addr > 4'h8 |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  AST_MC_BITS: assert property (busReq.rd && busReq.addr == 4'h0 |=> regRdData[7:2] == 6'h00)
    else $error("control upper bits set");
  AST_MC_RDBACK: assert property (mcWrRd |=> regRdData == ($past(busReq.wrData, 2) & 8'h03))
    else $error("control readback wrong");
  AST_MASK_OFF: assert property (busReq.wr && busReq.addr == 4'h7 && busReq.wrData == 8'h00
    |=> ##1 !irq)
    else $error("masked irq still high");
  AST_STICKY: assert property (irq && !irqWr && !$past(irqWr) |=> irq)
    else $error("irq dropped by itself");
  AST_SW_OUT: assert property (pbShareSwitchStrap && busReq.wr && busReq.addr == 4'h8
    |=> ##1 pbPinOut == $past(busReq.wrData, 2))
    else $error("switch lines wrong");
  AST_SW_OE: assert property (pbShareSwitchStrap && $past(rstn) && $past(rstn, 2)
    |-> pbPinOe == 8'hFF)
    else $error("switch lines not driven");
endmodule
`default_nettype wire

//--- verification/rcm_rc_osc.sv
// free-running resistor-capacitor oscillator on the port-D pins
`timescale 1ns/1ps
`default_nettype none
module rcm_rc_osc
(
  input wire logic clock,
  input wire logic [3:0] halfCycles,
  output logic [3:0] pin
);
  // ****
  // oscillator
  // ****
  logic [3:0] cnt = 4'h0;
  initial pin = 4'h0;
  always @(posedge clock)
  begin
    cnt <= (cnt >= halfCycles) ? 4'h0 : cnt + 4'h1;
    pin[3:1] <= pin[3:1] + 3'h1;
    if (cnt >= halfCycles)
      pin[0] <= ~pin[0];
  end
endmodule
`default_nettype wire

//--- verification/rcm_measure_unit_test.sv
// self-checking bench of the measurement unit
`timescale 1ns/1ps
`default_nettype none
module rcm_measure_unit_test;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  rcm_pkg::rcm_bus_req_t busReq = '0;
  logic [7:0] regRdData, pbPinOut, pbPinOe;
  logic [3:0] pdPinIn, pdGpioIn;
  logic [3:0] halfCycles = 4'h1;
  logic irq;
  logic rdSeen = 1'b0;
  logic [7:0] expQ[$];
  logic [15:0] rnd = 16'h0001;
  int err_total = 0;
  int n_checks = 0;
  int n;
  always #5 clock = ~clock;
  rcm_rc_osc OSC (.clock(clock), .halfCycles(halfCycles), .pin(pdPinIn));
  rcm_measure_unit DUT (.clock(clock), .rstn(rstn), .busReq(busReq), .regRdData(regRdData),
    .pdPinIn(pdPinIn), .pdShareOscStrap(1'b1), .pbShareSwitchStrap(1'b1), .pbGpioOut(8'h00),
    .pbGpioOe(8'h00), .pdGpioIn(pdGpioIn), .pbPinOut(pbPinOut), .pbPinOe(pbPinOe), .irq(irq));
  // ****
  // tasks
  // ****
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic op(input logic [3:0] a, input logic [7:0] d, input logic w, input logic r);
    @(posedge clock);
    busReq <= '{a, d, w, r};
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    op(a, d, 1'b1, 1'b0);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    expQ.push_back(e);
    op(a, 8'h00, 1'b0, 1'b1);
  endtask
  task automatic idle(input int k);
    repeat (k) op(4'h0, 8'h00, 1'b0, 1'b0);
    #1;
  endtask
  task automatic wait_irq();
    n = 0;
    while (irq !== 1'b1)
    begin
      @(posedge clock);
      #1;
      n++;
      if (n > 400)
      begin
        err_total++;
        report_and_stop();
      end
    end
  endtask
  always @(posedge clock)
    rdSeen <= busReq.rd;
  always @(negedge clock)
    if (rdSeen)
      chk("rd", {8'h00, regRdData}, {8'h00, expQ.pop_front()});
  // ****
  // sequence
  // ****
  initial
  begin
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    wr(4'hC, 8'hFF);
    for (int a = 0; a < 16; a++)
      rd(a[3:0], 8'h00);
    rnd = lfsr(rnd);
    wr(4'h0, rnd[7:0]);
    rd(4'h0, rnd[7:0] & 8'h03);
    for (int b = 2; b < 5; b += 2)
    begin
      rnd = lfsr(rnd);
      wr(b[3:0], rnd[7:0]);
      rd(b[3:0] + 4'h1, 8'h00);
      rd(b[3:0], 8'h00);
      wr(b[3:0] + 4'h1, rnd[15:8]);
      rd(b[3:0] + 4'h1, rnd[15:8]);
      rd(b[3:0], rnd[7:0]);
    end
    wr(4'h8, rnd[7:0]);
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h10);
    rd(4'h1, 8'h00);
    // software commits low byte before high
    wr(4'h0, 8'h02);
    wr(4'h7, 8'h10);
    wr(4'h2, 8'hF0);
    wr(4'h3, 8'hFF);
    wr(4'h4, 8'h00);
    wr(4'h5, 8'h00);
    wr(4'h1, 8'h10);
    rd(4'h3, 8'h00);
    wr(4'h3, 8'h00);
    idle(1);
    wait_irq();
    chk("len", {15'h0, n > 8 && n < 24}, 16'h0001);
    rd(4'h1, 8'h00);
    rd(4'h3, 8'h00);
    rd(4'h2, 8'h00);
    rd(4'h6, 8'h10);
    idle(5);
    chk("pdin", {12'h000, pdGpioIn}, 16'h0000);
    chk("irq", {15'h0, irq}, 16'h0001);
    wr(4'h7, 8'h00);
    idle(2);
    chk("irq", {15'h0, irq}, 16'h0000);
    wr(4'h7, 8'h10);
    wr(4'h6, 8'h10);
    idle(2);
    chk("irq", {15'h0, irq}, 16'h0000);
    halfCycles <= 4'h6;
    wr(4'h0, 8'h03);
    wr(4'h4, 8'hFC);
    wr(4'h5, 8'hFF);
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h00);
    wr(4'h1, 8'h30);
    idle(1);
    wait_irq();
    chk("len", {15'h0, n > 40 && n < 72}, 16'h0001);
    rd(4'h1, 8'h20);
    rd(4'h5, 8'h00);
    rd(4'h4, 8'h00);
    rd(4'h3, 8'h00);
    idle(3);
    report_and_stop();
  end
endmodule
bind rcm_measure_unit rcm_monitor MON (.clock(clock), .rstn(rstn), .busReq(busReq),
  .regRdData(regRdData), .pbShareSwitchStrap(pbShareSwitchStrap), .pbPinOut(pbPinOut),
  .pbPinOe(pbPinOe), .irq(irq));
`default_nettype wire
